// >>> design/pchsc_host.sv
`timescale 1ns/100ps

// What this block does
// [RULE1] Memory mode: host never pulses the I/O write strobe.
// [RULE2] I/O mode: write data held stable through the strobe's rising edge.
// [RULE3] IDE mode: I/O write strobe used exactly as in I/O mode.
// [RULE4] Memory mode: read strobe reads card data; data sampled while strobe active.
// [RULE5] I/O mode: read strobe only for card info structure or config reads.
// [RULE6] IDE mode selected by driving the mode select pin low.
// [RULE7] Memory mode: ready/busy high means a new transfer may start.
// [RULE8] After reset ready/busy stays low until the card finishes.
// [RULE9] No access of any kind while ready/busy shows busy. The code checks ready/busy only in memory mode.
// [RULE10] Card may hold ready/busy high when reset held from power-up.
// [RULE11] I/O mode: ready/busy low is an interrupt, pulse or level.
// [RULE12] IDE mode: interrupt line is active high.
// [RULE13] Memory cycles: attribute select high common, low attribute.
// [RULE14] I/O cycles: attribute select low while address is presented.
// [RULE15] IDE mode: attribute select tied high.
// [RULE16] I/O mode: read data valid only while I/O read strobe low.
// [RULE17] Card reset high in card modes, low in IDE mode.
// [RULE18] Pulse or level interrupt chosen by card setting, level after reset.
module pchsc_host (
  input  wire logic               ref_clk,
  input  wire logic               rst_n,
  input  wire pchsc_pkg::pchsc_mode_t mode,
  input  wire logic               card_reset_req,
  input  wire logic               req_valid,
  input  wire pchsc_pkg::pchsc_req_t req,
  output logic                    req_ready,
  output logic                    rsp_valid,
  output logic [15:0]             rsp_rdata,
  output logic                    irq,
  output logic                    io_write_strobe_n,
  output logic                    io_read_strobe_n,
  output logic                    mem_read_strobe_n,
  output logic                    mem_write_strobe_n,
  output logic                    attr_select_n,
  output logic                    ide_mode_select_n,
  output logic                    card_reset,
  output logic [15:0]             data_out,
  output logic                    data_oe_n,
  input  wire logic [15:0]        data_in,
  input  wire logic               ready_busy_line,
  input  wire logic               ide_interrupt_line
);

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_SETUP,
    ST_STROBE,
    ST_HOLD
  } pchsc_state_t;

  pchsc_state_t                      state_reg;
  logic [pchsc_pkg::PCHSC_CNT_W-1:0] cnt_reg;
  pchsc_pkg::pchsc_req_t             cur_reg;

  // Card accepts accesses only when ready; in memory mode busy blocks a start
  function automatic logic card_ready(input pchsc_pkg::pchsc_mode_t m, input logic rb);
    card_ready = (m != pchsc_pkg::PCHSC_MODE_MEM) || rb; // RULE7
  endfunction

  // Mode select and card reset pins; reset polarity flips in IDE mode
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ide_mode_select_n <= 1'b1;
      card_reset        <= 1'b1;
    end else begin
      ide_mode_select_n <= (mode != pchsc_pkg::PCHSC_MODE_IDE); // RULE6
      card_reset        <= (mode == pchsc_pkg::PCHSC_MODE_IDE) ? !card_reset_req : card_reset_req; // RULE17
    end
  end

  // Access sequencer: setup, strobe, hold
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= ST_IDLE;
      cnt_reg   <= '0;
      cur_reg   <= '0;
    end else begin
      unique case (state_reg)
        ST_IDLE: begin
          // Busy after reset blocks every access in memory mode; a reset request blocks in every mode
          if (req_valid && req_ready) begin // RULE9
            cur_reg   <= req;
            cnt_reg   <= pchsc_pkg::PCHSC_CNT_W'(pchsc_pkg::PCHSC_SETUP_CYC);
            state_reg <= ST_SETUP;
          end
        end
        ST_SETUP: begin
          if (cnt_reg == 1) begin
            cnt_reg   <= pchsc_pkg::PCHSC_CNT_W'(pchsc_pkg::PCHSC_STROBE_CYC);
            state_reg <= ST_STROBE;
          end else begin
            cnt_reg <= cnt_reg - 1'b1;
          end
        end
        ST_STROBE: begin
          if (cnt_reg == 1) begin
            cnt_reg   <= pchsc_pkg::PCHSC_CNT_W'(pchsc_pkg::PCHSC_HOLD_CYC);
            state_reg <= ST_HOLD;
          end else begin
            cnt_reg <= cnt_reg - 1'b1;
          end
        end
        ST_HOLD: begin
          if (cnt_reg == 1) begin
            state_reg <= ST_IDLE;
          end else begin
            cnt_reg <= cnt_reg - 1'b1;
          end
        end
      endcase
    end
  end

  // Ready toward user: idle, card out of reset and, in memory mode, not busy
  // Reset pin must read released first; a card held in reset from power-up still shows ready
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      req_ready <= 1'b0;
    end else begin
      req_ready <= (state_reg == ST_IDLE) && !(req_valid && req_ready) && !card_reset_req
                   && (card_reset == (mode == pchsc_pkg::PCHSC_MODE_IDE))
                   && card_ready(mode, ready_busy_line); // RULE8 RULE9
    end
  end

  // Strobe pins; the next state decides so pins change with it
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      io_write_strobe_n  <= pchsc_pkg::PCHSC_STROBE_IDLE;
      io_read_strobe_n   <= pchsc_pkg::PCHSC_STROBE_IDLE;
      mem_read_strobe_n  <= pchsc_pkg::PCHSC_STROBE_IDLE;
      mem_write_strobe_n <= pchsc_pkg::PCHSC_STROBE_IDLE;
    end else begin
      io_write_strobe_n  <= pchsc_pkg::PCHSC_STROBE_IDLE;
      io_read_strobe_n   <= pchsc_pkg::PCHSC_STROBE_IDLE;
      mem_read_strobe_n  <= pchsc_pkg::PCHSC_STROBE_IDLE;
      mem_write_strobe_n <= pchsc_pkg::PCHSC_STROBE_IDLE;
      if ((state_reg == ST_SETUP && cnt_reg == 1) || (state_reg == ST_STROBE && cnt_reg != 1)) begin
        if (mode == pchsc_pkg::PCHSC_MODE_MEM || cur_reg.cfg) begin
          // Memory mode never uses the I/O write strobe
          mem_read_strobe_n  <= cur_reg.write; // RULE1 RULE4 RULE5
          mem_write_strobe_n <= !cur_reg.write;
        end else begin
          // I/O and IDE modes share one strobe scheme
          io_write_strobe_n <= !cur_reg.write; // RULE2 RULE3
          io_read_strobe_n  <= cur_reg.write; // RULE16
        end
      end
    end
  end

  // Attribute select and data bus drive held through setup, strobe, hold
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      attr_select_n <= pchsc_pkg::PCHSC_COMMON_SPACE;
      data_out      <= pchsc_pkg::PCHSC_DATA_ZERO;
      data_oe_n     <= 1'b1;
    end else if (state_reg == ST_IDLE && !(req_valid && req_ready)) begin
      attr_select_n <= pchsc_pkg::PCHSC_COMMON_SPACE;
      data_oe_n     <= 1'b1;
    end else if (state_reg == ST_IDLE) begin
      data_out  <= req.wdata; // RULE2
      data_oe_n <= !req.write;
      unique case (mode)
        pchsc_pkg::PCHSC_MODE_MEM: attr_select_n <= req.attr ? pchsc_pkg::PCHSC_ATTR_SPACE
                                                             : pchsc_pkg::PCHSC_COMMON_SPACE; // RULE13
        pchsc_pkg::PCHSC_MODE_IO:  attr_select_n <= pchsc_pkg::PCHSC_ATTR_SPACE; // RULE14
        default:                   attr_select_n <= pchsc_pkg::PCHSC_COMMON_SPACE; // RULE15
      endcase
    end
  end

  // Read data sampled on the last strobe cycle, while the strobe is still low
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rsp_valid <= 1'b0;
      rsp_rdata <= pchsc_pkg::PCHSC_DATA_ZERO;
    end else begin
      rsp_valid <= (state_reg == ST_STROBE) && (cnt_reg == 1);
      if (state_reg == ST_STROBE && cnt_reg == 1 && !cur_reg.write) begin
        rsp_rdata <= data_in; // RULE4 RULE16
      end
    end
  end

  // Interrupt: low line in I/O, high line in IDE; following the level catches pulses of a cycle or more
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq <= 1'b0;
    end else begin
      unique case (mode)
        pchsc_pkg::PCHSC_MODE_IO:  irq <= !ready_busy_line; // RULE11 RULE18
        pchsc_pkg::PCHSC_MODE_IDE: irq <= ide_interrupt_line; // RULE12
        default:                   irq <= 1'b0; // RULE10
      endcase
    end
  end

  // I/O write strobe must be high in memory mode in the cycle after each idle cycle
  property p_no_io_write_strobe_n_mem;
    @(posedge ref_clk) disable iff (!rst_n)
      (mode == pchsc_pkg::PCHSC_MODE_MEM && state_reg == ST_IDLE) |=> io_write_strobe_n;
  endproperty
  a_no_io_write_strobe_n_mem: assert property (p_no_io_write_strobe_n_mem) else $error("io write strobe in memory mode"); // RULE1

  // Data is driven when the write strobe rises
  property p_data_at_rise;
    @(posedge ref_clk) disable iff (!rst_n)
      $rose(io_write_strobe_n) |-> !data_oe_n && data_out == $past(data_out);
  endproperty
  a_data_at_rise: assert property (p_data_at_rise) else $error("data not held at strobe rise"); // RULE2

  // Attribute select low during I/O cycles
  property p_io_attr;
    @(posedge ref_clk) disable iff (!rst_n)
      (!io_read_strobe_n || !io_write_strobe_n) && mode == pchsc_pkg::PCHSC_MODE_IO |-> !attr_select_n;
  endproperty
  a_io_attr: assert property (p_io_attr) else $error("attr select high in io cycle"); // RULE14

  // Attribute select high in IDE mode
  property p_ide_attr;
    @(posedge ref_clk) disable iff (!rst_n)
      $stable(mode) && mode == pchsc_pkg::PCHSC_MODE_IDE && $past(mode) == pchsc_pkg::PCHSC_MODE_IDE
        |=> attr_select_n;
  endproperty
  a_ide_attr: assert property (p_ide_attr) else $error("attr select low in ide mode"); // RULE15

  // A memory read strobe stays low for at least 8 cycles
  sequence s_strobe_low;
    !mem_read_strobe_n [*8];
  endsequence
  property p_strobe_width;
    @(posedge ref_clk) disable iff (!rst_n)
      $fell(mem_read_strobe_n) |-> s_strobe_low;
  endproperty
  a_strobe_width: assert property (p_strobe_width) else $error("read strobe too short"); // RULE4

  // No start while card reset is requested or, in memory mode, the card is busy
  property p_no_access_busy;
    @(posedge ref_clk) disable iff (!rst_n)
      req_ready |-> $past(!card_reset_req) && $past(card_ready(mode, ready_busy_line));
  endproperty
  a_no_access_busy: assert property (p_no_access_busy) else $error("access offered while busy"); // RULE9

  // Mode select low one cycle after the mode is IDE
  property p_mode_sel;
    @(posedge ref_clk) disable iff (!rst_n)
      mode == pchsc_pkg::PCHSC_MODE_IDE |=> !ide_mode_select_n;
  endproperty
  a_mode_sel: assert property (p_mode_sel) else $error("ide mode select not low"); // RULE6

  // Response arrives 20 to 40 cycles after the request is taken
  property p_rsp_time;
    @(posedge ref_clk) disable iff (!rst_n)
      (req_valid && req_ready) |-> ##[20:40] rsp_valid;
  endproperty
  a_rsp_time: assert property (p_rsp_time) else $error("response late"); // RULE7

endmodule // pchsc_host

// >>> design/pchsc_pkg.sv
package pchsc_pkg;

  // Host-side access modes of the card
  typedef enum logic [1:0] {
    PCHSC_MODE_MEM,
    PCHSC_MODE_IO,
    PCHSC_MODE_IDE
  } pchsc_mode_t;

  // Request from the host user logic
  typedef struct packed {
    logic        write;    // 1 write, 0 read
    logic        attr;     // Memory mode: 1 attribute space, 0 common
    logic        cfg;      // I/O mode: read of card info structure or config regs
    logic [15:0] wdata;
  } pchsc_req_t;

  // Strobe widths in ns and derived cycles at 200 MHz
  localparam int PCHSC_CLK_PERIOD_NS = 5;
  localparam int PCHSC_SETUP_NS      = 30;
  localparam int PCHSC_STROBE_NS     = 100;
  localparam int PCHSC_HOLD_NS       = 30;
  localparam int PCHSC_SETUP_CYC  = (PCHSC_SETUP_NS + PCHSC_CLK_PERIOD_NS - 1) / PCHSC_CLK_PERIOD_NS;
  localparam int PCHSC_STROBE_CYC = (PCHSC_STROBE_NS + PCHSC_CLK_PERIOD_NS - 1) / PCHSC_CLK_PERIOD_NS;
  localparam int PCHSC_HOLD_CYC   = (PCHSC_HOLD_NS + PCHSC_CLK_PERIOD_NS - 1) / PCHSC_CLK_PERIOD_NS;
  localparam int PCHSC_CNT_W      = 8;

  // Pin levels
  localparam logic PCHSC_STROBE_IDLE = 1'b1;
  localparam logic PCHSC_ATTR_SPACE  = 1'b0;
  localparam logic PCHSC_COMMON_SPACE = 1'b1;
  localparam logic [15:0] PCHSC_DATA_ZERO = 16'h0000;

endpackage

// >>> testbench/pchsc_card_model.sv
`timescale 1ns/100ps

// Behavioural card on the far side of the strobe pins
module pchsc_card_model #(parameter int BUSY_CYC = 10) (
  input  wire logic        ref_clk,
  input  wire logic        io_write_strobe_n,
  input  wire logic        io_read_strobe_n,
  input  wire logic        mem_read_strobe_n,
  input  wire logic        mem_write_strobe_n,
  input  wire logic        attr_select_n,
  input  wire logic        ide_mode_select_n,
  input  wire logic        card_reset,
  input  wire logic [15:0] data_out,
  input  wire logic        io_cfg,
  input  wire logic        card_event,
  output logic [15:0]      data_in,
  output logic             ready_busy_line,
  output logic             ide_interrupt_line
);
  logic        ide;
  logic        in_reset;
  logic        rd_mem;
  logic        rd_io;
  logic        pwr_rst  = 1'b1;
  logic [7:0]  busy_cnt = 8'h00;
  logic [15:0] last     = 16'h0000;
  logic [15:0] io_reg   = 16'h0000;
  logic [15:0] store [2];

  // Mode and reset polarity follow the select pin
  assign ide      = !ide_mode_select_n;
  assign in_reset = ide ? !card_reset : card_reset;

  // Busy countdown; held ready while reset has stood since power-up
  always @(posedge ref_clk) begin
    if (in_reset) busy_cnt <= 8'(BUSY_CYC);
    else if (busy_cnt != 8'h00) busy_cnt <= busy_cnt - 8'h01;
    if (!in_reset) pwr_rst <= 1'b0;
  end

  // Capture on trailing edges; I/O strobe ignored unless I/O or IDE
  always @(posedge mem_write_strobe_n) store[ide | attr_select_n] <= data_out;
  always @(posedge io_write_strobe_n) if (ide || io_cfg) io_reg <= data_out;

  // Bus only driven under a read strobe; released bus shows inverse
  assign rd_mem  = !mem_read_strobe_n;
  assign rd_io   = !io_read_strobe_n && (ide || io_cfg);
  assign data_in = rd_mem ? store[ide | attr_select_n] : rd_io ? io_reg : ~last;
  always @(posedge ref_clk) if (rd_mem || rd_io) last <= data_in;

  // Busy or level interrupt, the reset default; IDE line active high
  // Busy at once on any reset after power-up, so the host never sees a stale ready
  assign ready_busy_line    = (pwr_rst && in_reset)
                              | (!in_reset && busy_cnt == 8'h00 && !(card_event && !ide));
  assign ide_interrupt_line = ide && card_event;
endmodule  // pchsc_card_model

// >>> testbench/pchsc_host_tb.sv
`timescale 1ns/100ps

module pchsc_host_tb;
  logic                   ref_clk = 1'b0, rst_n = 1'b0, card_reset_req = 1'b0, req_valid = 1'b0;
  logic                   io_cfg = 1'b0, card_event = 1'b0;
  pchsc_pkg::pchsc_mode_t mode = pchsc_pkg::PCHSC_MODE_MEM;
  pchsc_pkg::pchsc_req_t  req = '0;
  logic                   req_ready, rsp_valid, irq, iow_n, ior_n, mrd_n, mwr_n, attr_n, ide_n, card_reset;
  logic                   data_oe_n, ready_busy_line, ide_interrupt_line;
  logic [15:0]            rsp_rdata, data_out, data_in;
  logic [31:0]            rnd = 32'h0000_25d2;
  logic [16:0]            note;
  logic [16:0]            exp_q[$];
  logic [15:0]            w [4];
  int                     error_cnt = 0;
  int                     num_checks = 0;

  always #2.5 ref_clk = ~ref_clk;

  pchsc_host DUT (.ref_clk(ref_clk), .rst_n(rst_n), .mode(mode), .card_reset_req(card_reset_req),
    .req_valid(req_valid), .req(req), .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata),
    .irq(irq), .io_write_strobe_n(iow_n), .io_read_strobe_n(ior_n), .mem_read_strobe_n(mrd_n),
    .mem_write_strobe_n(mwr_n), .attr_select_n(attr_n), .ide_mode_select_n(ide_n), .card_reset(card_reset),
    .data_out(data_out), .data_oe_n(data_oe_n), .data_in(data_in), .ready_busy_line(ready_busy_line),
    .ide_interrupt_line(ide_interrupt_line));

  pchsc_card_model #(.BUSY_CYC(10)) card (.ref_clk(ref_clk), .io_write_strobe_n(iow_n), .io_read_strobe_n(ior_n),
    .mem_read_strobe_n(mrd_n), .mem_write_strobe_n(mwr_n), .attr_select_n(attr_n), .ide_mode_select_n(ide_n),
    .card_reset(card_reset), .data_out(data_out), .io_cfg(io_cfg), .card_event(card_event), .data_in(data_in),
    .ready_busy_line(ready_busy_line), .ide_interrupt_line(ide_interrupt_line));

  function automatic logic [31:0] xorshift(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic results();
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  // One transfer; held until taken, then full hold time before the next
  task automatic access(input logic wr, input logic at, input logic cf, input logic [15:0] d, input logic [15:0] e);
    logic exp_attr;
    exp_attr  = (mode == pchsc_pkg::PCHSC_MODE_IDE) || (mode == pchsc_pkg::PCHSC_MODE_MEM && !at);
    req_valid <= 1'b1;
    req       <= '{write: wr, attr: at, cfg: cf, wdata: d};
    exp_q.push_back({!wr, e});
    do @(posedge ref_clk); while (req_ready !== 1'b1);
    req_valid <= 1'b0;
    repeat (2) @(posedge ref_clk);
    check({14'h0000, attr_n, data_oe_n}, {14'h0000, exp_attr, !wr});
    do @(posedge ref_clk); while (rsp_valid !== 1'b1);
    repeat (8) @(posedge ref_clk);
  endtask

  // Raise a card event and look at the host's view of it
  task automatic event_pulse(input logic [15:0] rdy, input logic [15:0] ir);
    card_event <= 1'b1;
    repeat (4) @(posedge ref_clk);
    check({15'h0000, req_ready}, rdy);
    check({15'h0000, irq}, ir);
    card_event <= 1'b0;
    repeat (4) @(posedge ref_clk);
    check({15'h0000, irq}, 16'h0000);
  endtask

  // Oldest note against each completed transfer; writes carry no data
  always @(posedge ref_clk) begin
    if (rsp_valid === 1'b1) begin
      if (exp_q.size() == 0) check(16'h0001, 16'h0000);
      note = exp_q.pop_front();
      if (note[16]) check(rsp_rdata, note[15:0]);
    end
  end

  // Watchdog well beyond the expected run
  initial begin
    #20000;
    error_cnt++;
    results();
  end

  initial begin
    for (int i = 0; i < 4; i++) begin
      rnd = xorshift(rnd);
      w[i] = rnd[15:0];
    end
    repeat (4) @(posedge ref_clk);
    check({15'h0000, ready_busy_line}, 16'h0001);
    rst_n <= 1'b1;
    repeat (2) @(posedge ref_clk);
    check({15'h0000, ready_busy_line}, 16'h0000);
    check({15'h0000, req_ready}, 16'h0000);
    // Memory mode: common and attribute spaces kept apart
    access(1'b1, 1'b0, 1'b0, w[0], 16'h0000);
    access(1'b1, 1'b1, 1'b0, w[1], 16'h0000);
    access(1'b0, 1'b0, 1'b0, 16'h0000, w[0]);
    access(1'b0, 1'b1, 1'b0, 16'h0000, w[1]);
    event_pulse(16'h0000, 16'h0000);
    // I/O mode: register and configuration reads
    mode   <= pchsc_pkg::PCHSC_MODE_IO;
    io_cfg <= 1'b1;
    repeat (4) @(posedge ref_clk);
    access(1'b1, 1'b0, 1'b0, w[2], 16'h0000);
    access(1'b0, 1'b0, 1'b0, 16'h0000, w[2]);
    access(1'b0, 1'b0, 1'b1, 16'h0000, w[1]);
    event_pulse(16'h0001, 16'h0001);
    // IDE mode: same strobes, inverted reset
    mode <= pchsc_pkg::PCHSC_MODE_IDE;
    repeat (4) @(posedge ref_clk);
    check({15'h0000, ide_n}, 16'h0000);
    check({15'h0000, attr_n}, 16'h0001);
    access(1'b1, 1'b0, 1'b0, w[3], 16'h0000);
    access(1'b0, 1'b0, 1'b0, 16'h0000, w[3]);
    event_pulse(16'h0001, 16'h0001);
    card_reset_req <= 1'b1;
    repeat (4) @(posedge ref_clk);
    check({15'h0000, card_reset}, 16'h0000);
    check({15'h0000, req_ready}, 16'h0000);
    card_reset_req <= 1'b0;
    repeat (20) @(posedge ref_clk);
    access(1'b0, 1'b0, 1'b0, 16'h0000, w[3]);
    results();
  end
endmodule  // pchsc_host_tb
